// ---- dlu_pkg.sv ----
// dlu_pkg: constants for the dual link interrupt unit
// shared by the unit and its timer leaf; no logic here
package dlu_pkg;
  localparam int NUM_SRC = 27;
  // source bit positions; bit 0 is the highest priority
  localparam int SRC_BUS    = 0;
  localparam int SRC_ADDR   = 4;
  localparam int SRC_RXDMA  = 8;
  localparam int SRC_TXDMA  = 10;
  localparam int SRC_TXFRM  = 12;
  localparam int SRC_RXFIFO = 14;
  localparam int SRC_TXFIFO = 16;
  localparam int SRC_RXBUF  = 18;
  localparam int SRC_IDLE   = 20;
  localparam int SRC_CD     = 22;
  localparam int SRC_SCP    = 24;
  localparam int SRC_TMR1   = 25;
  localparam int SRC_TMR0   = 26;
  // low vector code of each source, index 26 first
  localparam logic [26:0][3:0] SRC_CODE = {
    4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'h6, 4'h4, 4'hA, 4'h8,
    4'hB, 4'h9, 4'hA, 4'h8, 4'h7, 4'h5, 4'h7, 4'h5, 4'h6,
    4'h4, 4'hF, 4'hD, 4'hE, 4'hC, 4'hF, 4'hD, 4'hE, 4'hC};
  localparam logic [7:0] VEC_RESET    = 8'h00;
  localparam logic [3:0] IDLE_ONES    = 4'hF;
  localparam logic [2:0] SCP_LAST_BIT = 3'h7;
  localparam int         TIMER_W      = 8;
  localparam int         TIMER_DIV    = 1024;
  // receive status word layout per channel
  localparam int         RXS_CD_CHG   = 12;
  localparam int         RXS_CD_LEVEL = 15;
endpackage

// ---- dlu_timer.sv ----
// dlu_timer: host-presettable down counter on a divided tick
// assumes tick is a one-cycle strobe on mclk
`timescale 1ns/1ps
`default_nettype none
module dlu_timer #(
  parameter int W   = dlu_pkg::TIMER_W,
  parameter int DIV = dlu_pkg::TIMER_DIV
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // count source and host access
  input  wire logic         tick,
  input  wire logic         host_rd,
  input  wire logic         host_wr,
  input  wire logic [W-1:0] wdata,
  // state
  output logic      [W-1:0] value,
  output logic              wrap
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  if (DIV < 2 || W < 2) begin : g_bad
    $error("dlu_timer: DIV and W must be at least 2");
  end

  logic [DW-1:0] div;
  logic          count;

  // a pulse landing on a host access is lost, not deferred
  assign count = tick && (div == DW'(DIV - 1)) &&
                 !host_rd && !host_wr; // RULE15

  always_ff @(posedge mclk) begin
    if (rst) begin
      div <= '0;
    end else if (tick) begin
      div <= (div == DW'(DIV - 1)) ? '0 : div + DW'(1); // RULE14
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      value <= '0;
    end else if (host_wr) begin
      value <= wdata; // RULE14
    end else if (count) begin
      value <= value - W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrap <= 1'b0;
    end else begin
      wrap <= count && (value == '0); // RULE15
    end
  end

  timer_wrap_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
    (count && value == '0) |=> (wrap && value == '1))
    else $error("timer did not wrap from zero");
  timer_drop_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
    (host_rd && !host_wr) |=> $stable(value))
    else $error("timer counted during host read");
  timer_load_a: assert property (@(posedge mclk) disable iff (rst) // RULE14
    host_wr |=> (value == $past(wdata) && !wrap))
    else $error("timer preset not taken");
endmodule
`default_nettype wire

// ---- dlu_interrupt_unit.sv ----
// dlu_interrupt_unit: status bits, priority vector, fault actions
// assumes event inputs are one-cycle strobes on mclk; pins are async
// Function
// RULE1 - writing one to status raises interrupt
// RULE2 - twenty-seven fixed priorities, programmable upper vector
// RULE3 - bus and address errors codes C E D F
// RULE4 - dma complete codes 4 6 5 7
// RULE5 - transmit frame complete codes 5 and 7
// RULE6 - fifo overruns 8 A 9 B, buffers 8 A
// RULE7 - idle, carrier 4 6; port 2, timers 3 1
// RULE8 - receive dma complete only outside transparent mode
// RULE9 - transmit dma complete once last byte fetched
// RULE10 - frame complete after closing flag, not transparent
// RULE11 - receive idle after fifteen consecutive ones
// RULE12 - carrier change bit 12, live level bit 15
// RULE13 - carrier input usable as general purpose input
// RULE14 - two presettable timers on prescaler over 1024
// RULE15 - timer interrupt on wrap; drop pulse on access
// RULE16 - status bit clears only after read set
// RULE17 - receive fifo overrun suspends channel dma
// RULE18 - transmit underrun aborts frame, enters idle
// RULE19 - buffer overrun stops buffer, switches to alternate
// RULE20 - bus fault during dma flags and disables
// RULE21 - select or acknowledge during dma flags address
// RULE22 - port complete after eighth bit or select rise
// RULE23 - request pin low while enabled source pending
// RULE24 - each vector read latches top pending code
// RULE25 - zero write ignored unless bit read set
// RULE26 - vector reads zero after reset
`timescale 1ns/1ps
`default_nettype none
module dlu_interrupt_unit #(
  parameter int TIMER_DIV = dlu_pkg::TIMER_DIV
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // channel events, bit per channel
  input  wire logic [1:0]  rx_dma_done,
  input  wire logic [1:0]  rx_transparent,
  input  wire logic [1:0]  tx_dma_done,
  input  wire logic [1:0]  tx_frame_sent,
  input  wire logic [1:0]  tx_transparent,
  input  wire logic [1:0]  rx_fifo_overrun,
  input  wire logic [1:0]  tx_fifo_underrun,
  input  wire logic [1:0]  rx_buf_overrun,
  input  wire logic [1:0]  rx_alt_buf_ready,
  input  wire logic [1:0]  rx_reenable,
  input  wire logic [1:0]  rx_bit_valid,
  input  wire logic [1:0]  rx_bit,
  // asynchronous pins
  input  wire logic [1:0]  carrier_detect_in,
  input  wire logic        bus_fault_in,
  input  wire logic        chip_sel_in,
  input  wire logic        int_ack_in,
  input  wire logic        scp_slave_sel_in,
  // dma cycle state
  input  wire logic        dma_active,
  input  wire logic [1:0]  dma_chan,
  input  wire logic        transfer_ack,
  // serial control port and mode
  input  wire logic        scp_enable,
  input  wire logic        scp_master,
  input  wire logic        scp_bit_out,
  input  wire logic        scp_prescale_tick,
  input  wire logic [1:0]  timeslot_mode,
  // host status and enables
  input  wire logic        status_rd,
  input  wire logic        status_wr,
  input  wire logic [26:0] status_wdata,
  input  wire logic [18:0] src_enable,
  input  wire logic        bus_err_en,
  input  wire logic        addr_err_en,
  // vector
  input  wire logic        vec_base_wr,
  input  wire logic [3:0]  vec_base_data,
  input  wire logic        vec_read,
  // timers
  input  wire logic [1:0]  timer_rd,
  input  wire logic [1:0]  timer_wr,
  input  wire logic [7:0]  timer_wdata,
  // status and vector out
  output logic      [26:0] status_rdata,
  output logic      [7:0]  vector,
  output logic             irq_out,
  output logic             irq_oe,
  output logic      [15:0] rx_status_ch0,
  output logic      [15:0] rx_status_ch1,
  output logic      [1:0]  gp_in,
  output logic      [1:0]  gp_in_valid,
  // channel actions
  output logic      [3:0]  dma_disable,
  output logic      [1:0]  rx_dma_suspend,
  output logic      [1:0]  rx_enable_clear,
  output logic      [1:0]  tx_abort_idle,
  output logic      [1:0]  rx_buf_stop,
  output logic      [1:0]  rx_buf_switch,
  output logic      [7:0]  timer0_value,
  output logic      [7:0]  timer1_value
);
  localparam int NS = dlu_pkg::NUM_SRC;

  logic [5:0]    s1, s2, s3, lvl, pin_chg;
  logic [26:0]   stat, rd_set, hw_set, next_stat, clr, wset, en, pend;
  logic [3:0]    top_code, chan_hot, bus_hit, addr_hit;
  logic [1:0]    idle_hit;
  logic [2:0]    scp_cnt;
  logic          scp_done, tmr0_wrap, tmr1_wrap;

  // pins: three stages, level moves once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= {scp_slave_sel_in, int_ack_in, chip_sel_in, bus_fault_in,
             carrier_detect_in};
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign pin_chg = ~(s2 ^ s3) & (s3 ^ lvl);
  always_ff @(posedge mclk) begin
    if (rst) begin
      lvl <= '0;
    end else begin
      lvl <= lvl ^ pin_chg;
    end
  end

  // receive idle: saturating count of consecutive ones
  for (genvar c = 0; c < 2; c++) begin : g_idle
    logic [3:0] ones;
    always_ff @(posedge mclk) begin
      if (rst) begin
        ones <= '0;
      end else if (rx_bit_valid[c]) begin
        if (!rx_bit[c]) begin
          ones <= '0;
        end else if (ones != dlu_pkg::IDLE_ONES) begin
          ones <= ones + 4'h1;
        end
      end
    end
    assign idle_hit[c] = rx_bit_valid[c] & rx_bit[c] &
                         (ones == dlu_pkg::IDLE_ONES - 4'h1); // RULE11
  end

  // serial port: bit count in master mode, select edge in slave mode
  always_ff @(posedge mclk) begin
    if (rst || !scp_master) begin
      scp_cnt <= '0;
    end else if (scp_bit_out) begin
      scp_cnt <= scp_cnt + 3'h1;
    end
  end
  assign scp_done = scp_master ?
    (scp_bit_out && scp_cnt == dlu_pkg::SCP_LAST_BIT) :
    (pin_chg[5] && s3[5]); // RULE22

  // system faults: which dma channel was on the bus
  assign chan_hot = 4'h1 << dma_chan;
  assign bus_hit  = {4{dma_active & transfer_ack & lvl[2]}} &
                    chan_hot; // RULE20
  assign addr_hit = {4{dma_active & (lvl[3] | lvl[4])}} & chan_hot; // RULE21

  always_comb begin
    hw_set = '0;
    hw_set[dlu_pkg::SRC_BUS +: 4]    = bus_hit;
    hw_set[dlu_pkg::SRC_ADDR +: 4]   = addr_hit;
    hw_set[dlu_pkg::SRC_RXDMA +: 2]  = rx_dma_done & ~rx_transparent; // RULE8
    hw_set[dlu_pkg::SRC_TXDMA +: 2]  = tx_dma_done; // RULE9
    hw_set[dlu_pkg::SRC_TXFRM +: 2]  = tx_frame_sent &
                                       ~tx_transparent; // RULE10
    hw_set[dlu_pkg::SRC_RXFIFO +: 2] = rx_fifo_overrun;
    hw_set[dlu_pkg::SRC_TXFIFO +: 2] = tx_fifo_underrun;
    hw_set[dlu_pkg::SRC_RXBUF +: 2]  = rx_buf_overrun;
    hw_set[dlu_pkg::SRC_IDLE +: 2]   = idle_hit;
    hw_set[dlu_pkg::SRC_CD +: 2]     = pin_chg[1:0]; // RULE12
    hw_set[dlu_pkg::SRC_SCP]         = scp_done;
    hw_set[dlu_pkg::SRC_TMR1]        = tmr1_wrap;
    hw_set[dlu_pkg::SRC_TMR0]        = tmr0_wrap;
  end

  // host writes: ones set, zeros clear only bits already read set
  assign wset      = status_wr ? status_wdata : '0; // RULE1
  assign clr       = status_wr ? (~status_wdata & rd_set) : '0; // RULE25
  assign next_stat = (stat & ~clr) | wset | hw_set;
  assign en        = {src_enable, {4{addr_err_en}}, {4{bus_err_en}}};
  assign pend      = stat & en;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat   <= '0;
      rd_set <= '0;
    end else begin
      stat   <= next_stat;
      rd_set <= (rd_set | (status_rd ? stat : '0)) & next_stat; // RULE16
    end
  end
  assign status_rdata = stat;

  // lowest index wins; scanning downward leaves the top priority last
  always_comb begin
    top_code = 4'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        top_code = dlu_pkg::SRC_CODE[i]; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      vector <= dlu_pkg::VEC_RESET; // RULE26
    end else begin
      if (vec_base_wr) begin
        vector[7:4] <= vec_base_data; // RULE2
      end
      if (vec_read) begin
        vector[3:0] <= top_code; // RULE24
      end
    end
  end

  // open-drain request: pull low while anything enabled is pending
  assign irq_out = 1'b0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= |(next_stat & en); // RULE23
    end
  end

  // carrier level and change bit per channel, plus general input
  assign rx_status_ch0 = {lvl[0], 2'b00, stat[dlu_pkg::SRC_CD], 12'h000};
  assign rx_status_ch1 = {lvl[1], 2'b00, stat[dlu_pkg::SRC_CD + 1], 12'h000};
  assign gp_in_valid   = {2{~scp_enable}} & ~timeslot_mode; // RULE13
  always_ff @(posedge mclk) begin
    if (rst) begin
      gp_in <= '0;
    end else begin
      gp_in <= lvl[1:0] & gp_in_valid; // RULE13
    end
  end

  // channel actions copy their cause one cycle later; only the suspend level latches
  always_ff @(posedge mclk) begin
    if (rst) begin
      dma_disable     <= '0;
      rx_enable_clear <= '0;
      tx_abort_idle   <= '0;
      rx_buf_stop     <= '0;
      rx_buf_switch   <= '0;
    end else begin
      dma_disable     <= bus_hit | addr_hit; // RULE20 RULE21
      rx_enable_clear <= addr_hit[1:0]; // RULE21
      tx_abort_idle   <= tx_fifo_underrun | addr_hit[3:2]; // RULE18 RULE21
      rx_buf_stop     <= rx_buf_overrun; // RULE19
      rx_buf_switch   <= rx_buf_overrun & rx_alt_buf_ready; // RULE19
    end
  end
  // overrun wins over a re-enable in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_dma_suspend <= '0;
    end else begin
      rx_dma_suspend <= (rx_dma_suspend & ~rx_reenable) |
                        rx_fifo_overrun; // RULE17
    end
  end

  dlu_timer #(.W(dlu_pkg::TIMER_W), .DIV(TIMER_DIV)) u_tmr0 (
    .mclk    (mclk),
    .rst     (rst),
    .tick    (scp_prescale_tick),
    .host_rd (timer_rd[0]),
    .host_wr (timer_wr[0]),
    .wdata   (timer_wdata),
    .value   (timer0_value),
    .wrap    (tmr0_wrap)
  );
  dlu_timer #(.W(dlu_pkg::TIMER_W), .DIV(TIMER_DIV)) u_tmr1 (
    .mclk    (mclk),
    .rst     (rst),
    .tick    (scp_prescale_tick),
    .host_rd (timer_rd[1]),
    .host_wr (timer_wr[1]),
    .wdata   (timer_wdata),
    .value   (timer1_value),
    .wrap    (tmr1_wrap)
  );

  soft_set_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    (status_wr && $stable(en) && |(status_wdata & en)) |=> irq_oe)
    else $error("software set gave no request");
  irq_level_a: assert property (@(posedge mclk) disable iff (rst) // RULE23
    $stable(en) |-> (irq_oe == |(stat & en)))
    else $error("request pin disagrees with pending");
  clr_guard_a: assert property (@(posedge mclk) disable iff (rst) // RULE25
    status_wr |=> ((stat & $past(stat & ~rd_set)) == $past(stat & ~rd_set)))
    else $error("unread set bit was cleared");
  vec_latch_a: assert property (@(posedge mclk) disable iff (rst) // RULE24
    vec_read |=> (vector[3:0] == $past(top_code)))
    else $error("vector code not latched");
  vec_reset_a: assert property (@(posedge mclk) disable iff (rst) // RULE26
    $fell(rst) |-> (vector == 8'h00))
    else $error("vector not zero after reset");
  rx_dma_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
    $rose(stat[dlu_pkg::SRC_RXDMA]) |->
      $past((rx_dma_done[0] && !rx_transparent[0]) ||
            (status_wr && status_wdata[dlu_pkg::SRC_RXDMA])))
    else $error("receive dma complete without cause");
  bus_err_a: assert property (@(posedge mclk) disable iff (rst) // RULE20
    (dma_active && transfer_ack && lvl[2]) |=>
      (dma_disable[$past(dma_chan)] && stat[$past(dma_chan)]))
    else $error("bus fault not flagged");
  addr_tx_a: assert property (@(posedge mclk) disable iff (rst) // RULE21
    (dma_active && (lvl[3] || lvl[4]) && dma_chan == 2'h2) |=>
      (tx_abort_idle[0] && stat[dlu_pkg::SRC_ADDR + 2]))
    else $error("address error did not abort transmitter");
  suspend_a: assert property (@(posedge mclk) disable iff (rst) // RULE17
    (rx_fifo_overrun[0] ##1 !rx_reenable[0]) |=> rx_dma_suspend[0])
    else $error("overrun did not hold suspend");
  idle_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (rx_bit_valid[0] && rx_bit[0] && g_idle[0].ones == 4'hE) |=>
      stat[dlu_pkg::SRC_IDLE])
    else $error("fifteen ones gave no idle");
  cd_chg_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    $changed(lvl[0]) |-> (rx_status_ch0[dlu_pkg::RXS_CD_CHG] &&
      rx_status_ch0[dlu_pkg::RXS_CD_LEVEL] == lvl[0]))
    else $error("carrier change not flagged");
endmodule
`default_nettype wire

// ---- dlu_host_model.sv ----
// dlu_host_model: host side of the status and vector interface
// assumes the bench calls its tasks from falling mclk
`timescale 1ns/1ps
`default_nettype none
module dlu_host_model (
  // clock
  input  wire logic        mclk,
  // request pin pair from the unit
  input  wire logic        irq_out,
  input  wire logic        irq_oe,
  // host strobes
  output logic             status_rd,
  output logic             status_wr,
  output logic      [26:0] status_wdata,
  output logic             vec_read,
  output logic             vec_base_wr,
  output logic      [3:0]  vec_base_data,
  // resolved pin level
  output logic             irq_line
);
  // open drain with pull-up: released pin reads high
  assign irq_line = irq_oe ? irq_out : 1'b1;
  initial begin
    {vec_base_wr, vec_read, status_wr, status_rd} = 4'h0;
    status_wdata = '0;
    vec_base_data = 4'h0;
  end
  // k: 0 read status, 1 write status, 2 read vector, 3 write base
  task automatic op(input int k, input logic [26:0] d);
    @(negedge mclk);
    status_wdata = d;
    vec_base_data = d[3:0];
    {vec_base_wr, vec_read, status_wr, status_rd} = 4'h1 << k;
    @(negedge mclk);
    {vec_base_wr, vec_read, status_wr, status_rd} = 4'h0;
    @(negedge mclk);
  endtask
  // zero only lands on bits seen set, so read first
  task automatic clear();
    op(0, '0);
    op(1, '0);
  endtask
endmodule
`default_nettype wire

// ---- test_dual_link_interrupt_unit.sv ----
// test_dual_link_interrupt_unit: self-checking bench for the unit
// assumes dlu_pkg, dlu_timer and dlu_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_dual_link_interrupt_unit;
  localparam logic [0:26][3:0] CODE = 108'hCEDF_CEDF_4657_578A_9B8A_4646_231;
  logic        mclk = 0, rst = 1;
  logic [11:0] ev = '0, act;
  logic [1:0]  rx_transparent = '0, tx_transparent = '0;
  logic [1:0]  rx_alt_buf_ready = 2'b01, rx_reenable = '0;
  logic [1:0]  rx_bit_valid = '0, rx_bit = '0, carrier_detect_in = '0;
  logic [1:0]  dma_chan = '0, timeslot_mode = '0;
  logic [1:0]  timer_rd = '0, timer_wr = '0;
  logic        bus_fault_in = 0, chip_sel_in = 0, int_ack_in = 0;
  logic        scp_slave_sel_in = 0, dma_active = 0, transfer_ack = 0;
  logic        scp_enable = 0, scp_master = 0, scp_bit_out = 0;
  logic        scp_prescale_tick = 0, bus_err_en = 0, addr_err_en = 0;
  logic [18:0] src_enable = '0;
  logic [7:0]  timer_wdata = '0, vector, timer0_value, timer1_value;
  wire logic   status_rd, status_wr, vec_read, vec_base_wr, irq_line;
  wire logic [26:0] status_wdata;
  wire logic [3:0]  vec_base_data;
  wire logic [1:0]  rx_dma_done, tx_dma_done, tx_frame_sent;
  wire logic [1:0]  rx_fifo_overrun, tx_fifo_underrun, rx_buf_overrun;
  logic [26:0] status_rdata;
  logic        irq_out, irq_oe;
  logic [15:0] rx_status_ch0, rx_status_ch1;
  logic [1:0]  gp_in, gp_in_valid, rx_dma_suspend, rx_enable_clear;
  logic [1:0]  tx_abort_idle, rx_buf_stop, rx_buf_switch;
  logic [3:0]  dma_disable;
  int          checks = 0, bad_count = 0;
  assign {rx_buf_overrun, tx_fifo_underrun, rx_fifo_overrun,
          tx_frame_sent, tx_dma_done, rx_dma_done} = ev;
  // short divider keeps timer wraps within a few dozen cycles
  dlu_interrupt_unit #(.TIMER_DIV(4)) uut (.*);
  dlu_host_model host (.*);
  always #20 mclk = ~mclk;
  // action strobes end before the checks run, so collect them
  always @(posedge mclk) act <= act | {dma_disable, rx_enable_clear,
    tx_abort_idle, rx_buf_stop, rx_buf_switch};
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset();
    check("reset vector", vector, 0);
    check("reset misc", {irq_oe, timer0_value, timer1_value}, 0);
  endtask
  task automatic t_priority();
    host.op(3, 27'h9);
    host.op(1, 27'h7FF_FFFF);
    check("masked", irq_line, 1);
    host.op(1, '0);
    check("unread", status_rdata, 27'h7FF_FFFF);
    src_enable = '1;
    bus_err_en = 1;
    addr_err_en = 1;
    cyc(1);
    check("raised", irq_line, 0);
    host.op(0, '0);
    for (int i = 0; i < 27; i++) begin
      host.op(2, '0);
      check("code", vector[3:0], CODE[i]);
      check("base", vector[7:4], 4'h9);
      host.op(1, 27'h7FF_FFFF << (i + 1));
    end
    host.op(2, '0);
    check("empty", {irq_line, vector}, 9'h190);
  endtask
  task automatic t_events();
    logic [11:0] e;
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 2; c++) begin
        act = '0;
        ev[2*k+c] = 1'b1;
        cyc(1);
        ev = '0;
        cyc(2);
        e = '0;
        if (k == 4) e[4+c] = 1'b1;
        if (k == 5) e[2+c] = 1'b1;
        if (k == 5 && c == 0) e[0] = 1'b1;
        check("event", status_rdata, 1 << (8 + 2*k + c));
        check("pin", irq_line, 0);
        check("actions", act, e);
        check("suspend", rx_dma_suspend, 32'(k == 3) << c);
        rx_reenable = 2'b11;
        cyc(1);
        rx_reenable = '0;
        host.clear();
        check("cleared", {rx_dma_suspend, status_rdata}, 0);
      end
    end
    rx_transparent = '1;
    tx_transparent = '1;
    ev = 12'h033;
    cyc(1);
    ev = '0;
    cyc(2);
    check("transparent", status_rdata, 0);
  endtask
  task automatic t_faults();
    for (int c = 0; c < 4; c++) begin
      dma_active = 1;
      dma_chan = 2'(c);
      act = '0;
      bus_fault_in = 1;
      cyc(5);
      transfer_ack = 1;
      cyc(1);
      transfer_ack = 0;
      bus_fault_in = 0;
      cyc(5);
      check("bus error", status_rdata, 1 << c);
      check("bus stop", act, 12'h100 << c);
      host.clear();
      act = '0;
      {int_ack_in, chip_sel_in} = c[0] ? 2'b10 : 2'b01;
      cyc(6);
      {int_ack_in, chip_sel_in} = 2'b00;
      dma_active = 0;
      cyc(5);
      check("addr error", status_rdata, 16 << c);
      check("addr stop", act, (12'h100 << c) |
        (c < 2 ? 12'h040 << c : 12'h010 << (c - 2)));
      host.clear();
    end
  endtask
  task automatic t_idle();
    rx_bit = 2'b11;
    for (int i = 1; i <= 15; i++) begin
      rx_bit_valid = 2'b11;
      cyc(1);
      rx_bit_valid = '0;
      cyc(1);
      if (i == 14) check("idle 14", status_rdata, 0);
    end
    check("idle 15", status_rdata, 3 << 20);
    rx_bit = '0;
    host.clear();
  endtask
  task automatic t_carrier();
    timeslot_mode = 2'b10;
    carrier_detect_in = 2'b11;
    cyc(6);
    check("level ch1", rx_status_ch1, 16'h9000);
    check("change", status_rdata, 3 << 22);
    check("gp", {gp_in_valid, gp_in[0]}, 3'b011);
    scp_enable = 1;
    cyc(1);
    check("gp off", gp_in_valid, 0);
    scp_enable = 0;
    carrier_detect_in = 2'b00;
    cyc(6);
    check("level ch0", rx_status_ch0[15], 0);
    host.clear();
  endtask
  task automatic t_port();
    scp_enable = 1;
    scp_master = 1;
    for (int i = 1; i <= 8; i++) begin
      scp_bit_out = 1;
      cyc(1);
      scp_bit_out = 0;
      cyc(1);
      if (i == 7) check("seven bits", status_rdata, 0);
    end
    check("eight bits", status_rdata, 1 << 24);
    host.clear();
    scp_master = 0;
    scp_slave_sel_in = 1;
    cyc(6);
    check("select rise", status_rdata, 1 << 24);
    scp_slave_sel_in = 0;
    scp_enable = 0;
    host.clear();
  endtask
  task automatic ticks(input logic [1:0] rd);
    for (int i = 1; i <= 4; i++) begin
      scp_prescale_tick = 1;
      if (i == 4) timer_rd = rd;
      cyc(1);
      scp_prescale_tick = 0;
      timer_rd = '0;
      cyc(1);
    end
    cyc(1);
  endtask
  task automatic t_timers();
    timer_wdata = 8'h01;
    timer_wr = 2'b01;
    cyc(1);
    timer_wdata = 8'h00;
    timer_wr = 2'b10;
    cyc(1);
    timer_wr = '0;
    cyc(1);
    check("preset", {timer0_value, timer1_value}, 16'h0100);
    ticks(2'b00);
    check("count", {timer0_value, timer1_value}, 16'h00FF);
    check("wrap 1", status_rdata, 1 << 25);
    host.clear();
    ticks(2'b01);
    check("dropped", {timer0_value, timer1_value}, 16'h00FE);
    ticks(2'b00);
    check("wrap 0", {timer0_value, timer1_value}, 16'hFFFD);
    check("wrap 0 bit", status_rdata, 1 << 26);
    host.clear();
  endtask
  initial begin
    cyc(3);
    rst = 0;
    cyc(1);
    t_reset();
    t_timers();
    t_priority();
    t_events();
    t_faults();
    t_idle();
    t_carrier();
    t_port();
    print_verdict();
  end
  // whole run needs about 600 cycles
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
